// file: src/limit_alert_diag_flags.sv
// Diagnostic flag register and current and bus limit threshold registers.
`timescale 1ns/100ps
`default_nettype none
module limit_alert_diag_flags #(
  parameter int CUR_W  = limit_alert_diag_pkg::CUR_W,
  parameter int BUS_W  = limit_alert_diag_pkg::BUS_W,
  parameter int TEMP_W = limit_alert_diag_pkg::TEMP_W,
  parameter int PWR_W  = limit_alert_diag_pkg::PWR_W
) (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              rst,
  // Register port
  input  wire logic [7:0]        regAddr,
  input  wire logic              regWrite,
  input  wire logic              regRead,
  input  wire logic [15:0]       regWrData,
  output logic [15:0]            regRdData,
  // Configuration held outside this block
  input  wire logic              alertLatchMode,
  input  wire logic              averagedCompareSel,
  input  wire logic [15:0]       tempThreshold,
  input  wire logic [15:0]       powerThreshold,
  // Conversion events
  input  wire logic              rawSampleValid,
  input  wire logic              avgResultValid,
  input  wire logic              convTrigger,
  input  wire logic              accumClearCtl,
  input  wire logic              chargeOverflowEvt,
  input  wire logic              arithOverflowEvt,
  input  wire logic              trimChecksumErr,
  // Measurements
  input  wire logic [CUR_W-1:0]  current,
  input  wire logic [BUS_W-1:0]  busVoltage,
  input  wire logic [TEMP_W-1:0] temperature,
  input  wire logic [PWR_W-1:0]  power,
  // Status
  output logic [15:0]            diagFlags,
  output logic                   anyLimitFlag
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic [15:0] curOverThr;
    logic [15:0] curUnderThr;
    logic [15:0] busOverThr;
    logic [15:0] busUnderThr;
    logic [limit_alert_diag_pkg::NUM_LIMITS-1:0] limitFlags;
    logic        charge_overflow_flag;
    logic        arithOf;
    logic        convDone;
    logic        trimOk;
    logic [15:0] rdData;
  } state_t;

  localparam state_t STATE_RST = '{
    curOverThr:  limit_alert_diag_pkg::RST_CUR_OVER,
    curUnderThr: limit_alert_diag_pkg::RST_CUR_UNDER,
    busOverThr:  limit_alert_diag_pkg::RST_BUS_OVER,
    busUnderThr: limit_alert_diag_pkg::RST_BUS_UNDER,
    limitFlags:  '0,
    charge_overflow_flag:    1'b0,
    arithOf:     1'b0,
    convDone:    1'b0,
    trimOk:      1'b1,
    rdData:      limit_alert_diag_pkg::READ_ZERO
  };

  state_t state_r;
  state_t state_nxt;

  logic [limit_alert_diag_pkg::NUM_LIMITS-1:0] cond;
  logic        sample;
  logic        diagRead;
  logic [15:0] diagWord;

  // ==========================================================================
  // Comparators
  limit_compare #(
    .CUR_W  (CUR_W),
    .BUS_W  (BUS_W),
    .TEMP_W (TEMP_W),
    .PWR_W  (PWR_W)
  ) compare (
    .current     (current),
    .busVoltage  (busVoltage),
    .temperature (temperature),
    .power       (power),
    .curOverThr  (state_r.curOverThr),
    .curUnderThr (state_r.curUnderThr),
    .busOverThr  (state_r.busOverThr),
    .busUnderThr (state_r.busUnderThr),
    .tempThr     (tempThreshold),
    .powerThr    (powerThreshold),
    .cond        (cond)
  );

  // ==========================================================================
  // Decode
  // Limits are judged only on a sample strobe; between strobes the measurement
  // inputs may change freely without disturbing the flags.
  assign sample   = averagedCompareSel ? avgResultValid : rawSampleValid;
  assign diagRead = regRead && (regAddr == limit_alert_diag_pkg::ADDR_DIAG);

  always_comb begin
    diagWord = '0;
    diagWord[limit_alert_diag_pkg::BIT_CHARGE_OF] = state_r.charge_overflow_flag;
    diagWord[limit_alert_diag_pkg::BIT_ARITH_OF]  = state_r.arithOf;
    diagWord[limit_alert_diag_pkg::BIT_RESERVED]  = 1'b0;
    diagWord[limit_alert_diag_pkg::LIMIT_BASE +: limit_alert_diag_pkg::NUM_LIMITS] =
      state_r.limitFlags;
    diagWord[limit_alert_diag_pkg::BIT_CONV_DONE] = state_r.convDone;
    diagWord[limit_alert_diag_pkg::BIT_TRIM_OK]   = state_r.trimOk;
  end

  // ==========================================================================
  // Next state
  always_comb begin
    state_nxt = state_r;

    // Threshold writes; host writes to the diagnostic word change nothing.
    if (regWrite) begin
      case (regAddr)
        limit_alert_diag_pkg::ADDR_CUR_OVER:  state_nxt.curOverThr = regWrData;
        limit_alert_diag_pkg::ADDR_CUR_UNDER: state_nxt.curUnderThr = regWrData;
        limit_alert_diag_pkg::ADDR_BUS_OVER:
          state_nxt.busOverThr = regWrData & limit_alert_diag_pkg::BUS_THR_MASK;
        limit_alert_diag_pkg::ADDR_BUS_UNDER:
          state_nxt.busUnderThr = regWrData & limit_alert_diag_pkg::BUS_THR_MASK;
        default: state_nxt.curOverThr = state_r.curOverThr;
      endcase
    end

    // Limit flags: set wins over a read clear in the same cycle.
    for (int i = 0; i < limit_alert_diag_pkg::NUM_LIMITS; i++) begin
      if (alertLatchMode) begin
        state_nxt.limitFlags[i] = (state_r.limitFlags[i] && !diagRead) || (sample && cond[i]);
      end else if (sample) begin
        state_nxt.limitFlags[i] = cond[i];
      end
    end

    // Conversion done: in transparent mode only a new trigger clears it.
    if (avgResultValid) begin
      state_nxt.convDone = 1'b1;
    end else if (convTrigger || (alertLatchMode && diagRead)) begin
      state_nxt.convDone = 1'b0;
    end

    if (chargeOverflowEvt) begin
      state_nxt.charge_overflow_flag = 1'b1;
    end else if (accumClearCtl) begin
      state_nxt.charge_overflow_flag = 1'b0;
    end

    if (arithOverflowEvt) begin
      state_nxt.arithOf = 1'b1;
    end else if (convTrigger || accumClearCtl) begin
      state_nxt.arithOf = 1'b0;
    end

    // A checksum failure is permanent until reset; nothing restores it.
    if (trimChecksumErr) begin
      state_nxt.trimOk = 1'b0;
    end

    // Read data shows the value from before any clear caused by this read.
    if (regRead) begin
      case (regAddr)
        limit_alert_diag_pkg::ADDR_DIAG:      state_nxt.rdData = diagWord;
        limit_alert_diag_pkg::ADDR_CUR_OVER:  state_nxt.rdData = state_r.curOverThr;
        limit_alert_diag_pkg::ADDR_CUR_UNDER: state_nxt.rdData = state_r.curUnderThr;
        limit_alert_diag_pkg::ADDR_BUS_OVER:  state_nxt.rdData = state_r.busOverThr;
        limit_alert_diag_pkg::ADDR_BUS_UNDER: state_nxt.rdData = state_r.busUnderThr;
        default: state_nxt.rdData = limit_alert_diag_pkg::READ_ZERO;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_r <= STATE_RST;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  assign regRdData    = state_r.rdData;
  assign diagFlags    = diagWord;
  assign anyLimitFlag = |state_r.limitFlags;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  AST_CHARGE_SET: assert property (chargeOverflowEvt |=> state_r.charge_overflow_flag [*1] ##0
    diagFlags[limit_alert_diag_pkg::BIT_CHARGE_OF])
    else $error("Charge overflow flag not set after overflow.");

  AST_CHARGE_HOLD: assert property (state_r.charge_overflow_flag && !accumClearCtl |=> state_r.charge_overflow_flag)
    else $error("Charge overflow flag dropped without accumulator clear.");

  AST_ARITH_SET: assert property (arithOverflowEvt |=> diagFlags[limit_alert_diag_pkg::BIT_ARITH_OF])
    else $error("Arithmetic overflow flag not set.");

  AST_ARITH_CLR: assert property (!arithOverflowEvt && (convTrigger || accumClearCtl)
    |=> !state_r.arithOf)
    else $error("Arithmetic overflow flag not cleared by trigger or clear.");

  AST_ARITH_HOLD: assert property (state_r.arithOf && !convTrigger && !accumClearCtl
    |=> state_r.arithOf)
    else $error("Arithmetic overflow flag dropped on its own.");

  AST_RESERVED: assert property (diagRead |=> regRdData[limit_alert_diag_pkg::BIT_RESERVED] == 1'b0)
    else $error("Reserved diagnostic bit read as one.");

  AST_LIMIT_SET: assert property (sample && |cond
    |=> (state_r.limitFlags & $past(cond)) == $past(cond))
    else $error("Limit flag not set on a sampled fault.");

  AST_LATCH_CLEAR: assert property (alertLatchMode && diagRead && !sample
    |=> state_r.limitFlags == '0 ##0 regRdData == $past(diagWord))
    else $error("Latched limit flags not cleared by diagnostic read.");

  AST_LATCH_HOLD: assert property (alertLatchMode && !diagRead |=>
    (state_r.limitFlags & $past(state_r.limitFlags)) == $past(state_r.limitFlags))
    else $error("Latched limit flag dropped without a read.");

  AST_TRANSPARENT: assert property (!alertLatchMode && sample |=> state_r.limitFlags == $past(cond))
    else $error("Transparent limit flags do not follow the fault.");

  AST_CONV_DONE: assert property (avgResultValid |=> state_r.convDone ##1
    (state_r.convDone || $past(convTrigger) || $past(diagRead)))
    else $error("Conversion done flag not set or lost early.");

  AST_TRIM: assert property (!state_r.trimOk || trimChecksumErr |=> !state_r.trimOk)
    else $error("Trim status not held low after checksum error.");

  AST_ZERO_TRIP: assert property (sample && current == '0
    && state_r.curOverThr[15] |=> state_r.limitFlags[limit_alert_diag_pkg::LIM_CUR_OVER])
    else $error("Zero current did not trip a negative over threshold.");

  AST_BUS_RSVD: assert property (regWrite && regAddr == limit_alert_diag_pkg::ADDR_BUS_OVER
    ##[1:2] regRead && regAddr == limit_alert_diag_pkg::ADDR_BUS_OVER |=> regRdData[15] == 1'b0)
    else $error("Reserved bus threshold bit stored a write.");

  // ==========================================================================
  // Assertions on thresholds and the quieter flag paths
  // These guard paths that a short test reaches only once, if at all.
  AST_DIAG_RSVD: assert property (
    diagFlags[limit_alert_diag_pkg::BIT_RESERVED] == 1'b0)
    else $error("Reserved diagnostic bit shown as one.");

  AST_BUS_MSB: assert property (
    !state_r.busOverThr[limit_alert_diag_pkg::THR_W-1] &&
    !state_r.busUnderThr[limit_alert_diag_pkg::THR_W-1])
    else $error("Reserved bus threshold bit held a one.");

  AST_TRANSP_HOLD: assert property (!alertLatchMode && !sample
    |=> $stable(state_r.limitFlags))
    else $error("Transparent limit flags changed between sample strobes.");

  AST_CONV_CLR: assert property (convTrigger && !avgResultValid
    |=> !state_r.convDone)
    else $error("Conversion done flag not cleared by a new trigger.");

  AST_CONV_READ: assert property (alertLatchMode && diagRead && !avgResultValid
    |=> !state_r.convDone)
    else $error("Latched conversion done flag not cleared by a read.");

  AST_CONV_KEEP: assert property (!alertLatchMode && state_r.convDone && !convTrigger
    |=> state_r.convDone)
    else $error("Transparent conversion done flag lost without a trigger.");

  AST_CHARGE_CLR: assert property (accumClearCtl && !chargeOverflowEvt
    |=> !state_r.charge_overflow_flag)
    else $error("Charge overflow flag not cleared by accumulator clear.");

  AST_CUR_OVER_WR: assert property (
    regWrite && regAddr == limit_alert_diag_pkg::ADDR_CUR_OVER
    |=> state_r.curOverThr == $past(regWrData))
    else $error("Current over threshold did not take the written value.");

  AST_CUR_UNDER_WR: assert property (
    regWrite && regAddr == limit_alert_diag_pkg::ADDR_CUR_UNDER
    |=> state_r.curUnderThr == $past(regWrData))
    else $error("Current under threshold did not take the written value.");

  AST_BUS_OVER_WR: assert property (
    regWrite && regAddr == limit_alert_diag_pkg::ADDR_BUS_OVER
    |=> state_r.busOverThr == ($past(regWrData) & limit_alert_diag_pkg::BUS_THR_MASK))
    else $error("Bus over threshold did not take the masked write.");

  AST_THR_HOLD: assert property (!regWrite |=> $stable(state_r.curOverThr)
    && $stable(state_r.curUnderThr))
    else $error("Current threshold changed without a write.");

  COV_LATCH_READ: cover property (alertLatchMode && anyLimitFlag && diagRead ##1 !anyLimitFlag);
  COV_TRANSPARENT: cover property (!alertLatchMode && anyLimitFlag ##[1:20] !anyLimitFlag);
  COV_ARITH_CLEAR: cover property (state_r.arithOf && convTrigger ##1 !state_r.arithOf);
  COV_TRIM_FAIL: cover property (trimChecksumErr ##1 !state_r.trimOk);

endmodule // limit_alert_diag_flags
`default_nettype wire

// file: src/limit_alert_diag_pkg.sv
// Constants, register map and field layout of the diagnostic flag and limit block.
package limit_alert_diag_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0]  ADDR_DIAG      = 8'h0b;
  localparam logic [7:0]  ADDR_CUR_OVER  = 8'h0c;
  localparam logic [7:0]  ADDR_CUR_UNDER = 8'h0d;
  localparam logic [7:0]  ADDR_BUS_OVER  = 8'h0e;
  localparam logic [7:0]  ADDR_BUS_UNDER = 8'h0f;

  // ==========================================================================
  // Reset values and masks
  localparam logic [15:0] RST_CUR_OVER   = 16'h7fff;
  localparam logic [15:0] RST_CUR_UNDER  = 16'h8000;
  localparam logic [15:0] RST_BUS_OVER   = 16'h7fff;
  localparam logic [15:0] RST_BUS_UNDER  = 16'h0000;
  localparam logic [15:0] BUS_THR_MASK   = 16'h7fff;
  localparam logic [15:0] READ_ZERO      = 16'h0000;

  // ==========================================================================
  // Diagnostic word field positions
  localparam int BIT_CHARGE_OF = 10;
  localparam int BIT_ARITH_OF  = 9;
  localparam int BIT_RESERVED  = 8;
  localparam int LIMIT_BASE    = 2;
  localparam int BIT_CONV_DONE = 1;
  localparam int BIT_TRIM_OK   = 0;
  localparam int NUM_LIMITS    = 6;

  // Index of each limit within the limit vector, bit LIMIT_BASE upward.
  localparam int LIM_POWER     = 0;
  localparam int LIM_BUS_LOW   = 1;
  localparam int LIM_BUS_HIGH  = 2;
  localparam int LIM_CUR_UNDER = 3;
  localparam int LIM_CUR_OVER  = 4;
  localparam int LIM_TEMP      = 5;

  // ==========================================================================
  // Measurement widths and threshold width
  localparam int THR_W  = 16;
  localparam int CUR_W  = 20;
  localparam int BUS_W  = 20;
  localparam int TEMP_W = 16;
  localparam int PWR_W  = 24;

endpackage

// file: src/limit_compare.sv
// Scaled comparison of measurements against their limit thresholds.
`timescale 1ns/100ps
`default_nettype none
module limit_compare #(
  parameter int CUR_W  = limit_alert_diag_pkg::CUR_W,
  parameter int BUS_W  = limit_alert_diag_pkg::BUS_W,
  parameter int TEMP_W = limit_alert_diag_pkg::TEMP_W,
  parameter int PWR_W  = limit_alert_diag_pkg::PWR_W
) (
  // Measurements
  input  wire logic [CUR_W-1:0]  current,
  input  wire logic [BUS_W-1:0]  busVoltage,
  input  wire logic [TEMP_W-1:0] temperature,
  input  wire logic [PWR_W-1:0]  power,
  // Thresholds
  input  wire logic [15:0]       curOverThr,
  input  wire logic [15:0]       curUnderThr,
  input  wire logic [15:0]       busOverThr,
  input  wire logic [15:0]       busUnderThr,
  input  wire logic [15:0]       tempThr,
  input  wire logic [15:0]       powerThr,
  // Fault conditions, one per limit
  output logic [limit_alert_diag_pkg::NUM_LIMITS-1:0] cond
);

  // ==========================================================================
  // Alignment
  // Only the top bits that share the threshold weighting are compared, so the
  // low measurement bits below one threshold step never trip a limit.
  logic [15:0] curTop;
  logic [15:0] busTop;
  logic [15:0] pwrTop;

  assign curTop = current[CUR_W-1 -: limit_alert_diag_pkg::THR_W];
  assign busTop = busVoltage[BUS_W-1 -: limit_alert_diag_pkg::THR_W];
  assign pwrTop = power[PWR_W-1 -: limit_alert_diag_pkg::THR_W];

  // ==========================================================================
  // Comparators
  always_comb begin
    cond = '0;
    cond[limit_alert_diag_pkg::LIM_TEMP] =
      $signed(temperature[TEMP_W-1 -: limit_alert_diag_pkg::THR_W]) > $signed(tempThr);
    // A negative over threshold trips at zero current, as zero exceeds it.
    cond[limit_alert_diag_pkg::LIM_CUR_OVER] = $signed(curTop) > $signed(curOverThr);
    cond[limit_alert_diag_pkg::LIM_CUR_UNDER] = $signed(curTop) < $signed(curUnderThr);
    cond[limit_alert_diag_pkg::LIM_BUS_HIGH] = busTop > busOverThr;
    cond[limit_alert_diag_pkg::LIM_BUS_LOW] = busTop < busUnderThr;
    cond[limit_alert_diag_pkg::LIM_POWER] = pwrTop > powerThr;
  end

endmodule // limit_compare
`default_nettype wire

// file: verif/register_host_model.sv
// Host-side model that issues register reads and writes to the limit block.
`timescale 1ns/100ps
`default_nettype none
module register_host_model (
  // Clock
  input  wire logic        clock,
  // Register port
  output logic [7:0]       regAddr,
  output logic             regWrite,
  output logic             regRead,
  output logic [15:0]      regWrData,
  input  wire logic [15:0] regRdData
);
  // ==========================================================================
  // Transfers
  // Released lines show the inverse of the last value, so stale data is never taken as live.
  // The callers keep the over threshold above the under threshold when both are negative.
  initial begin
    regAddr = 8'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
    regWrData = 16'h0000;
  end

  task automatic write_reg(input logic [7:0] addr, input logic [15:0] data);
    @(negedge clock);
    regAddr = addr;
    regWrData = data;
    regWrite = 1'b1;
    @(negedge clock);
    regWrite = 1'b0;
    regAddr = ~regAddr;
    regWrData = ~regWrData;
  endtask

  task automatic read_reg(input logic [7:0] addr, output logic [15:0] data);
    @(negedge clock);
    regAddr = addr;
    regRead = 1'b1;
    @(negedge clock);
    regRead = 1'b0;
    regAddr = ~regAddr;
    data = regRdData;
  endtask
endmodule // register_host_model
`default_nettype wire

// file: verif/testbench.sv
// Self-checking bench for the diagnostic flag and limit threshold block.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  // ==========================================================================
  // Signals
  logic        clock;
  logic        rst;
  logic [7:0]  regAddr;
  logic        regWrite;
  logic        regRead;
  logic [15:0] regWrData;
  logic [15:0] regRdData;
  logic        alertLatchMode;
  logic        averagedCompareSel;
  logic [15:0] tempThreshold;
  logic [15:0] powerThreshold;
  logic [6:0]  evts;
  logic [19:0] current;
  logic [19:0] busVoltage;
  logic [15:0] temperature;
  logic [23:0] power;
  logic [15:0] diagFlags;
  logic        anyLimitFlag;
  int          fail_count;
  int          n_checks;
  int          cycles;

  // ==========================================================================
  // Instances
  limit_alert_diag_flags limit_alert_diag_flags_inst (
    .clock(clock), .rst(rst), .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
    .regWrData(regWrData), .regRdData(regRdData), .alertLatchMode(alertLatchMode),
    .averagedCompareSel(averagedCompareSel), .tempThreshold(tempThreshold),
    .powerThreshold(powerThreshold), .rawSampleValid(evts[0]), .avgResultValid(evts[1]),
    .convTrigger(evts[2]), .accumClearCtl(evts[3]), .chargeOverflowEvt(evts[4]),
    .arithOverflowEvt(evts[5]), .trimChecksumErr(evts[6]), .current(current),
    .busVoltage(busVoltage), .temperature(temperature), .power(power),
    .diagFlags(diagFlags), .anyLimitFlag(anyLimitFlag));

  register_host_model register_host_model_inst (
    .clock(clock), .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
    .regWrData(regWrData), .regRdData(regRdData));

  always #2.5 clock = ~clock;

  // ==========================================================================
  // Shared tasks
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic dchk(input logic [15:0] exp);
    check(diagFlags, exp, "diag word");
  endtask

  task automatic rdchk(input logic [7:0] addr, input logic [15:0] exp);
    logic [15:0] d;
    register_host_model_inst.read_reg(addr, d);
    check(d, exp, "read data");
  endtask

  task automatic wr(input logic [7:0] addr, input logic [15:0] data);
    register_host_model_inst.write_reg(addr, data);
  endtask

  // Strobes land on one edge; the flags are judged at the following falling edge.
  task automatic meas(input logic [19:0] c, input logic [19:0] b, input logic [15:0] t,
                      input logic [23:0] p, input logic [6:0] m);
    @(negedge clock);
    current = c;
    busVoltage = b;
    temperature = t;
    power = p;
    evts = m;
    @(negedge clock);
    evts = 7'h00;
  endtask

  task automatic ev(input logic [6:0] m);
    meas(current, busVoltage, temperature, power, m);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic test_reset();
    rdchk(8'h0c, 16'h7fff);
    rdchk(8'h0d, 16'h8000);
    rdchk(8'h0e, 16'h7fff);
    rdchk(8'h0f, 16'h0000);
    rdchk(8'h0b, 16'h0001);
    rdchk(8'h20, 16'h0000);
  endtask

  task automatic test_writes();
    wr(8'h0c, 16'h8001);
    rdchk(8'h0c, 16'h8001);
    wr(8'h0e, 16'hffff);
    rdchk(8'h0e, 16'h7fff);
    wr(8'h0f, 16'h8005);
    rdchk(8'h0f, 16'h0005);
    wr(8'h0b, 16'h00fe);
    dchk(16'h0001);
    wr(8'h0c, 16'h0100);
  endtask

  task automatic test_transparent();
    meas(20'h02000, 20'h00010, 16'h0100, 24'h020000, 7'h01);
    dchk(16'h00cd);
    check({15'h0000, anyLimitFlag}, 16'h0001, "any limit");
    wr(8'h0d, 16'hff00);
    wr(8'h0e, 16'h1000);
    meas(20'hfe000, 20'h20000, 16'h0000, 24'h000000, 7'h01);
    dchk(16'h0031);
    meas(20'h00000, 20'h00100, 16'h0000, 24'h000000, 7'h01);
    dchk(16'h0001);
    check({15'h0000, anyLimitFlag}, 16'h0000, "any limit");
  endtask

  task automatic test_averaged();
    averagedCompareSel = 1'b1;
    meas(20'h02000, 20'h00100, 16'h0000, 24'h000000, 7'h01);
    dchk(16'h0001);
    ev(7'h02);
    dchk(16'h0043);
    ev(7'h04);
    dchk(16'h0041);
    meas(20'h00000, 20'h00100, 16'h0000, 24'h000000, 7'h02);
    dchk(16'h0003);
    wr(8'h0c, 16'hfff0);
    ev(7'h02);
    dchk(16'h0043);
    wr(8'h0c, 16'h0100);
  endtask

  task automatic test_latch();
    alertLatchMode = 1'b1;
    meas(20'h02000, 20'h00100, 16'h0000, 24'h000000, 7'h02);
    meas(20'h00000, 20'h00100, 16'h0000, 24'h000000, 7'h02);
    dchk(16'h0043);
    rdchk(8'h0b, 16'h0043);
    dchk(16'h0001);
    ev(7'h02);
    dchk(16'h0003);
    ev(7'h04);
    dchk(16'h0001);
  endtask

  task automatic test_overflow();
    ev(7'h10);
    dchk(16'h0401);
    ev(7'h20);
    dchk(16'h0601);
    ev(7'h04);
    dchk(16'h0401);
    ev(7'h20);
    ev(7'h08);
    dchk(16'h0001);
    ev(7'h40);
    rdchk(8'h0b, 16'h0000);
  endtask

  // ==========================================================================
  // Main sequence
  // The ceiling is dozens of times the under one hundred cycles the scenarios need.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      $display("wrong value at %0t: run did not finish", $time);
      give_verdict();
    end
  end

  initial begin
    clock = 1'b0;
    rst = 1'b1;
    alertLatchMode = 1'b0;
    averagedCompareSel = 1'b0;
    tempThreshold = 16'h0080;
    powerThreshold = 16'h0100;
    evts = 7'h00;
    current = 20'h00000;
    busVoltage = 20'h00100;
    temperature = 16'h0000;
    power = 24'h000000;
    fail_count = 0;
    n_checks = 0;
    cycles = 0;
    repeat (2) @(negedge clock);
    rst = 1'b0;
    test_reset();
    test_writes();
    test_transparent();
    test_averaged();
    test_latch();
    test_overflow();
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
